//--- lgd_regs.sv
// Group dimming register bank with per-module group/independent selection
// Function
// [R1] Bit n of the selection register puts module n under group control.
// [R2] All selection bits reset to zero: independent control.
// [R3] Group brightness, 8 bits, resets to ff, linear scale.
// [R4] Group mixes A, B, C, 8 bits each, reset to zero.
// [R5] Brightness for modules 0 to 2, reset to ff, linear scale.
// [R6] Every register is writable and reads back its last value.
// [R7] Curve select one gives logarithmic curve, zero gives linear.
// [R8] All-outputs-off forces every output brightness and mix to zero.
// [R9] Grouped module uses group brightness and group mixes A, B, C.
`timescale 1ns/1ps
module lgd_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port from the serial protocol engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Device configuration bits held elsewhere
  input wire logic log_curve_sel,
  input wire logic all_outputs_off,
  // Per-module own settings for modules 3 to 7 and per-output mixes
  input wire logic [7:0] module3_dim_value,
  input wire logic [7:0] module4_dim_value,
  input wire logic [7:0] module5_dim_value,
  input wire logic [7:0] module6_dim_value,
  input wire logic [7:0] module7_dim_value,
  input wire logic [191:0] own_mix,
  // To PWM stage: per-module brightness and three mixes each
  output logic [63:0] module_dim,
  output logic [191:0] module_mix,
  // Raw register contents
  output logic [7:0] module_group_select,
  output logic [7:0] group_dim_level
);
  logic [7:0] sel_q, sel_d;
  logic [7:0] gdim_q, gdim_d;
  logic [7:0] amix_q, amix_d;
  logic [7:0] bmix_q, bmix_d;
  logic [7:0] cmix_q, cmix_d;
  logic [7:0] dim0_q, dim0_d;
  logic [7:0] dim1_q, dim1_d;
  logic [7:0] dim2_q, dim2_d;
  logic [7:0] rdata_q, rdata_d;
  logic [63:0] raw_dim;

  // Selection register; one bit per module
  always_comb begin
    sel_d = sel_q;
    if (reg_wr && reg_addr == lgd_pkg::ADDR_MODULE_GROUP_SELECT) begin
      sel_d = reg_wdata; // [R1] [R6]
    end
  end

  // Selection flops; reset leaves every module independent
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= lgd_pkg::RST_MODULE_GROUP_SELECT; // [R2]
    end else begin
      sel_q <= sel_d;
    end
  end

  // Shared group level and mixes; unmapped writes fall through unchanged
  always_comb begin
    gdim_d = gdim_q;
    amix_d = amix_q;
    bmix_d = bmix_q;
    cmix_d = cmix_q;
    if (reg_wr) begin
      if (reg_addr == lgd_pkg::ADDR_GROUP_DIM_LEVEL) begin
        gdim_d = reg_wdata; // [R3] [R6]
      end else if (reg_addr == lgd_pkg::ADDR_GROUP_A_MIX) begin
        amix_d = reg_wdata; // [R4] [R6]
      end else if (reg_addr == lgd_pkg::ADDR_GROUP_B_MIX) begin
        bmix_d = reg_wdata; // [R4]
      end else if (reg_addr == lgd_pkg::ADDR_GROUP_C_MIX) begin
        cmix_d = reg_wdata; // [R4]
      end
    end
  end

  // Group flops; full level but no mix until the host sets one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gdim_q <= lgd_pkg::RST_GROUP_DIM_LEVEL; // [R3]
      amix_q <= lgd_pkg::RST_GROUP_MIX; // [R4]
      bmix_q <= lgd_pkg::RST_GROUP_MIX;
      cmix_q <= lgd_pkg::RST_GROUP_MIX;
    end else begin
      gdim_q <= gdim_d;
      amix_q <= amix_d;
      bmix_q <= bmix_d;
      cmix_q <= cmix_d;
    end
  end

  // Own levels of modules 0 to 2
  always_comb begin
    dim0_d = dim0_q;
    dim1_d = dim1_q;
    dim2_d = dim2_q;
    if (reg_wr) begin
      if (reg_addr == lgd_pkg::ADDR_MODULE0_DIM_LEVEL) begin
        dim0_d = reg_wdata; // [R5] [R6]
      end else if (reg_addr == lgd_pkg::ADDR_MODULE1_DIM_LEVEL) begin
        dim1_d = reg_wdata; // [R5]
      end else if (reg_addr == lgd_pkg::ADDR_MODULE2_DIM_LEVEL) begin
        dim2_d = reg_wdata; // [R5]
      end
    end
  end

  // Own level flops; full scale until written
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dim0_q <= lgd_pkg::RST_MODULE_DIM_LEVEL; // [R5]
      dim1_q <= lgd_pkg::RST_MODULE_DIM_LEVEL;
      dim2_q <= lgd_pkg::RST_MODULE_DIM_LEVEL;
    end else begin
      dim0_q <= dim0_d;
      dim1_q <= dim1_d;
      dim2_q <= dim2_d;
    end
  end

  // Read decode; data is registered so the engine sees it one cycle later
  always_comb begin
    rdata_d = rdata_q;
    reg_hit = 1'b1;
    if (reg_addr == lgd_pkg::ADDR_MODULE_GROUP_SELECT) begin
      rdata_d = sel_q; // [R6]
    end else if (reg_addr == lgd_pkg::ADDR_GROUP_DIM_LEVEL) begin
      rdata_d = gdim_q;
    end else if (reg_addr == lgd_pkg::ADDR_GROUP_A_MIX) begin
      rdata_d = amix_q;
    end else if (reg_addr == lgd_pkg::ADDR_GROUP_B_MIX) begin
      rdata_d = bmix_q;
    end else if (reg_addr == lgd_pkg::ADDR_GROUP_C_MIX) begin
      rdata_d = cmix_q;
    end else if (reg_addr == lgd_pkg::ADDR_MODULE0_DIM_LEVEL) begin
      rdata_d = dim0_q;
    end else if (reg_addr == lgd_pkg::ADDR_MODULE1_DIM_LEVEL) begin
      rdata_d = dim1_q;
    end else if (reg_addr == lgd_pkg::ADDR_MODULE2_DIM_LEVEL) begin
      rdata_d = dim2_q;
    end else begin
      rdata_d = lgd_pkg::UNMAPPED_READ;
      reg_hit = 1'b0;
    end
    if (!reg_rd) begin
      rdata_d = rdata_q; // Hold last answer between reads
    end
  end

  // Own brightness per module; modules 3 to 7 come from outside
  assign raw_dim = {module7_dim_value, module6_dim_value, module5_dim_value,
                    module4_dim_value, module3_dim_value, dim2_q, dim1_q, dim0_q};

  // Per-module source selection, curve, global off and output flops
  generate
    for (genvar m = 0; m < lgd_pkg::NUM_MODULES; m++) begin : g_mod
      logic [7:0] src_dim;
      logic [7:0] curve_dim;
      logic [23:0] src_mix;
      logic [7:0] out_dim_q, out_dim_d;
      logic [23:0] out_mix_q, out_mix_d;

      // Grouped module ignores its own level and mixes
      assign src_dim = sel_q[m] ? gdim_q : raw_dim[m*8 +: 8]; // [R1] [R9]
      assign src_mix = sel_q[m] ? {cmix_q, bmix_q, amix_q} : own_mix[m*24 +: 24]; // [R9]

      // Curve sits after the source choice so a group shares one mapping
      lgd_curve i_lgd_curve (
        .log_sel(log_curve_sel),
        .code_in(src_dim),
        .code_out(curve_dim)
      );

      // Global off wins over every level and mix
      always_comb begin
        out_dim_d = curve_dim;
        out_mix_d = src_mix;
        if (all_outputs_off) begin
          out_dim_d = '0; // [R8]
          out_mix_d = '0; // [R8]
        end
      end

      // Output flops; the PWM stage sees a change one cycle late
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          out_dim_q <= '0;
          out_mix_q <= '0;
        end else begin
          out_dim_q <= out_dim_d;
          out_mix_q <= out_mix_d;
        end
      end

      assign module_dim[m*8 +: 8] = out_dim_q;
      assign module_mix[m*24 +: 24] = out_mix_q;
    end
  endgenerate

  // Read data flop; holds the last answer for a slow protocol engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= lgd_pkg::UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign module_group_select = sel_q;
  assign group_dim_level = gdim_q;
endmodule : lgd_regs

//--- lgd_pkg.sv
// Package: register map, reset values and curve shift of the group dimming registers
package lgd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_MODULES = 8;
  localparam int unsigned NUM_DIRECT = 3;
  // Register offsets
  localparam logic [7:0] ADDR_MODULE_GROUP_SELECT = 8'h02;
  localparam logic [7:0] ADDR_GROUP_DIM_LEVEL = 8'h03;
  localparam logic [7:0] ADDR_GROUP_A_MIX = 8'h04;
  localparam logic [7:0] ADDR_GROUP_B_MIX = 8'h05;
  localparam logic [7:0] ADDR_GROUP_C_MIX = 8'h06;
  localparam logic [7:0] ADDR_MODULE0_DIM_LEVEL = 8'h07;
  localparam logic [7:0] ADDR_MODULE1_DIM_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_MODULE2_DIM_LEVEL = 8'h09;
  // Reset values
  localparam logic [7:0] RST_MODULE_GROUP_SELECT = 8'h00;
  localparam logic [7:0] RST_GROUP_DIM_LEVEL = 8'hff;
  localparam logic [7:0] RST_GROUP_MIX = 8'h00;
  localparam logic [7:0] RST_MODULE_DIM_LEVEL = 8'hff;
  // Answer to an unmapped read
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Log curve: code = code * (code + 1) / 256, close to code^2 / 255, computed as (code * code + code) >> 8
  localparam int unsigned LOG_SHIFT = 8;
endpackage : lgd_pkg

//--- lgd_curve.sv
// Brightness curve: linear pass-through or square-law (logarithmic-like) mapping
`timescale 1ns/1ps
module lgd_curve (
  // Select and code
  input wire logic log_sel,
  input wire logic [7:0] code_in,
  // Mapped code
  output logic [7:0] code_out
);
  logic [15:0] sq;

  // Square law approximates a perceptual curve; ff stays ff, 00 stays 00
  always_comb begin
    sq = 16'(code_in) * 16'(code_in) + 16'(code_in);
    if (log_sel) begin
      code_out = sq[15:lgd_pkg::LOG_SHIFT]; // [R7]
    end else begin
      code_out = code_in; // [R7]
    end
  end
endmodule : lgd_curve

//--- lgd_regs_asserts.sv
// Checker of the group dimming register bank
`timescale 1ns/1ps
module lgd_regs_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic log_curve_sel,
  input wire logic all_outputs_off,
  input wire logic [63:0] module_dim,
  input wire logic [7:0] module_group_select,
  input wire logic [7:0] group_dim_level
);
  // Module 0 grouped and outputs live
  wire grp0 = module_group_select[0] && !all_outputs_off;
  wire unmap = reg_addr > 8'h09 || reg_addr < 8'h02;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sel_write_a: assert property (reg_wr && reg_addr == 8'h02 |=>
    module_group_select == $past(reg_wdata)) else $error("select write lost");
  reset_value_a: assert property ($rose(resetn) |->
    module_group_select == 8'h00 && group_dim_level == 8'hff) else $error("bad reset");
  sel_hold_a: assert property (!(reg_wr && reg_addr == 8'h02) |=>
    $stable(module_group_select)) else $error("select drifted");
  read_back_a: assert property (reg_rd && !reg_wr && reg_addr == 8'h03 |=>
    reg_rdata == $past(group_dim_level)) else $error("read data wrong");
  unmapped_a: assert property (reg_rd && unmap |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  outputs_off_a: assert property (all_outputs_off |=> module_dim == 64'h0)
    else $error("outputs not off");
  group_dim_a: assert property (grp0 && !log_curve_sel |=>
    module_dim[7:0] == $past(group_dim_level)) else $error("group level unused");
  log_curve_a: assert property (grp0 && log_curve_sel && group_dim_level == 8'h80 |=>
    module_dim[7:0] == 8'h40) else $error("log curve wrong");
  cover property (reg_wr && reg_addr == 8'h02);
  cover property (all_outputs_off && module_group_select[0]);
  cover property (reg_rd && unmap);
endmodule : lgd_regs_asserts
bind lgd_regs lgd_regs_asserts i_lgd_regs_asserts (.clk(clk), .resetn(resetn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .log_curve_sel(log_curve_sel), .all_outputs_off(all_outputs_off),
  .module_dim(module_dim), .module_group_select(module_group_select),
  .group_dim_level(group_dim_level));

//--- lgd_host.sv
// Host model of the register port, driving at the falling edge
`timescale 1ns/1ps
module lgd_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  logic last_hit = 1'b0;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // One strobe cycle; released lines scrambled so stale values never pass
  task automatic io(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(posedge clk);
    last_hit = reg_hit; // Decode taken while the address still stands
    @(negedge clk);
    q = reg_rdata;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask : io
endmodule : lgd_host

//--- lgd_regs_bench.sv
// Self-checking bench of the group dimming register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module lgd_regs_bench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic log_sel = 1'b0;
  logic off = 1'b0;
  logic [7:0] od = 8'h33;
  logic [191:0] om = {24{8'h5a}};
  logic wr, rd, hit;
  logic [7:0] addr, wd, rdat, sel, gdim, q;
  logic [63:0] dim;
  logic [191:0] mix;
  int err_count = 0;
  int tests_run = 0;
  logic [7:0] rv [8] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
  logic [7:0] nv [8] = '{8'h01, 8'h80, 8'h11, 8'h22, 8'h44, 8'h7e, 8'h01, 8'hfe};
  always #10 clk = ~clk;
  lgd_host i_lgd_host (.clk(clk), .reg_rdata(rdat), .reg_hit(hit), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wd));
  lgd_regs i_lgd_regs (.clk(clk), .resetn(resetn), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_hit(hit), .log_curve_sel(log_sel),
    .all_outputs_off(off), .module3_dim_value(od), .module4_dim_value(od),
    .module5_dim_value(od), .module6_dim_value(od), .module7_dim_value(od), .own_mix(om),
    .module_dim(dim), .module_mix(mix), .module_group_select(sel), .group_dim_level(gdim));
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Register map sweep, then the output paths
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      i_lgd_host.io(1'b0, 8'h02 + i[7:0], 8'h00, q);
      `CHK("reset value", rv[i], q)
      `CHK("mapped hit", 1'b1, i_lgd_host.last_hit)
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) i_lgd_host.io(1'b1, 8'h02 + i[7:0], nv[i], q);
    // Writes just outside the map must leave every register alone
    i_lgd_host.io(1'b1, 8'h01, 8'hff, q);
    i_lgd_host.io(1'b1, 8'h0a, 8'hff, q);
    `CHK("select reg", 8'h01, sel)
    `CHK("group reg", 8'h80, gdim)
    for (int i = 0; i < 8; i++) begin
      i_lgd_host.io(1'b0, 8'h02 + i[7:0], 8'h00, q);
      `CHK("read back", nv[i], q)
    end
    i_lgd_host.io(1'b0, 8'h0a, 8'h00, q);
    `CHK("unmapped", 8'h00, q)
    `CHK("unmapped hit", 1'b0, i_lgd_host.last_hit)
    $display("test read back done");
    // Module 0 grouped, modules 1 and 3 on their own settings
    `CHK("group dim", 8'h80, dim[7:0])
    `CHK("group mix", 24'h442211, mix[23:0])
    `CHK("own dim", 8'h01, dim[15:8])
    `CHK("own mix", 24'h5a5a5a, mix[47:24])
    `CHK("module3 dim", 8'h33, dim[31:24])
    log_sel = 1'b1;
    @(negedge clk);
    `CHK("log dim", 8'h40, dim[7:0])
    `CHK("log low", 8'h00, dim[15:8])
    off = 1'b1;
    @(negedge clk);
    `CHK("off dim", 64'h0, dim)
    `CHK("off mix", 192'h0, mix)
    $display("test output paths done");
    // Second reset in mid-run brings the registers back
    off = 1'b0;
    resetn = 1'b0;
    @(negedge clk);
    `CHK("reset select", 8'h00, sel)
    `CHK("reset level", 8'hff, gdim)
    resetn = 1'b1;
    i_lgd_host.io(1'b0, 8'h07, 8'h00, q);
    `CHK("reset module0", 8'hff, q)
    i_lgd_host.io(1'b0, 8'h04, 8'h00, q);
    `CHK("reset mix a", 8'h00, q)
    $display("test mid-run reset done");
    close_out();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule : lgd_regs_bench
